// ### src/rhl_pkg.sv
package rhl_pkg;
  // actual link state codes
  localparam logic [2:0] LS_DISCONNECTED = 3'h1;
  localparam logic [2:0] LS_CONNECTING = 3'h2;
  localparam logic [2:0] LS_SIGNED_ON = 3'h3;
  localparam logic [2:0] LS_CONNECTED = 3'h4;
  localparam logic [2:0] LS_ERROR = 3'h5;
  localparam logic [2:0] LS_PROGRAM = 3'h6;
  localparam logic [2:0] LS_BUSY = 3'h7;
  // commanded link state codes
  localparam logic [2:0] CMD_CONNECT = 3'h1;
  localparam logic [2:0] CMD_DISCONNECT = 3'h2;
  localparam logic [2:0] CMD_RECONNECT = 3'h3;
  localparam logic [2:0] CMD_ERROR = 3'h4;
  // auto mode values
  localparam logic [1:0] AUTO_OFF = 2'h0;
  localparam logic [1:0] AUTO_RECONNECT = 2'h1;
  localparam logic [1:0] AUTO_DISCONNECT = 2'h2;
  localparam logic [1:0] AUTO_RESET = 2'h0;
  localparam logic [7:0] LOOKAHEAD_RESET = 8'h00;
  localparam logic OPERATIVE_RESET = 1'b1;
  // tag memory geometry
  localparam int ADDR_W = 16;
  localparam int BUF_DEPTH = 256;
  localparam logic [15:0] USER_END_RESET = 16'h1DF0;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } rhl_req_t;

  typedef struct packed {
    logic done;
    logic err;
  } rhl_resp_t;
endpackage

// ### src/rhl_lookahead.sv
module rhl_lookahead (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rhl_pkg::rhl_req_t ptrRead,
  input wire logic [7:0] count,
  input wire logic [15:0] userEnd,
  input wire logic [7:0] tagByte,
  output logic [15:0] tagAddr,
  output logic tagRdEn,
  input wire rhl_pkg::rhl_req_t bufRead,
  output logic [7:0] bufData,
  output rhl_pkg::rhl_resp_t bufResp,
  output logic busy
);
  logic [7:0] mem [rhl_pkg::BUF_DEPTH];
  logic [rhl_pkg::BUF_DEPTH-1:0] okFlag_ff;
  logic [15:0] base_ff;
  logic [7:0] idx_ff;
  logic [7:0] left_ff;
  logic run_ff;
  logic wrPend_ff;
  logic [7:0] wrIdx_ff;
  logic wrOk_ff;
  logic hopPend_ff;
  logic [7:0] hopIdx_ff;
  logic hopOk_ff;

  function automatic logic inUser(input logic [15:0] a, input logic [15:0] lim);
    return a < lim;
  endfunction

  assign tagAddr = base_ff + 16'(idx_ff);
  assign tagRdEn = run_ff && inUser(tagAddr, userEnd);
  assign busy = run_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
      base_ff <= 16'h0000;
      idx_ff <= 8'h00;
      left_ff <= 8'h00;
    end else if (!run_ff && ptrRead.valid && count != 8'h00) begin
      run_ff <= 1'b1;
      base_ff <= ptrRead.addr;
      idx_ff <= 8'h00;
      left_ff <= count;
    end else if (run_ff) begin
      idx_ff <= idx_ff + 8'h01;
      left_ff <= left_ff - 8'h01;
      if (left_ff == 8'h01) begin
        run_ff <= 1'b0;
      end
    end
  end

  // tag byte lands two cycles after the internal address: one for the registered
  // pins of the parent, one for the tag's own answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hopPend_ff <= 1'b0;
      hopIdx_ff <= 8'h00;
      hopOk_ff <= 1'b0;
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 8'h00;
      wrOk_ff <= 1'b0;
    end else begin
      hopPend_ff <= run_ff;
      hopIdx_ff <= idx_ff;
      hopOk_ff <= tagRdEn;
      wrPend_ff <= hopPend_ff;
      wrIdx_ff <= hopIdx_ff;
      wrOk_ff <= hopOk_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (wrPend_ff) begin
      mem[wrIdx_ff] <= tagByte;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      okFlag_ff <= '0;
    end else if (wrPend_ff) begin
      okFlag_ff[wrIdx_ff] <= wrOk_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bufData <= 8'h00;
      bufResp <= '0;
    end else begin
      bufResp.done <= bufRead.valid;
      bufResp.err <= bufRead.valid && !okFlag_ff[bufRead.addr[7:0]];
      bufData <= bufRead.valid ? mem[bufRead.addr[7:0]] : 8'h00;
    end
  end
endmodule

// ### src/rhl_link_ctrl.sv
// Behaviour
// - control inputs are accepted at any time, tag present or not; commands are refused while busy.
// - actual state codes 1..7 as disconnected..busy.
// - disconnected: field off, no sign-on, captured data stays readable.
// - connecting: field on, next tag may sign on.
// - sign-on enters signed-on state; prefetch runs there.
// - connected: tag held, data exchange possible.
// - session break without sign-off: error, field off, no sign-on.
// - busy while a command is processed; program only transiently.
// - state changes by command or event only; host writes rejected.
// - connect turns field on, awaits sign-on.
// - disconnect ends session, tag and field off, sign-on blocked.
// - reconnect ends session, field stays on.
// - error command signs tag off then enters error.
// - commands may take effect later, e.g. connect waits for tag.
// - auto mode resets to zero, inactive.
// - auto one: after signed-on phase return to connecting.
// - auto two: after signed-on phase go to disconnected.
// - any auto mode refuses direct tag access commands.
// - operative flag set at boot; host clears it.
// - pointer read also fetches look-ahead count bytes, kept internally.
// - look-ahead bytes beyond user area flagged, read returns error.
module rhl_link_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdCode,
  input wire logic stateWrite,
  input wire logic autoWrite,
  input wire logic [1:0] autoValue,
  input wire logic operClear,
  input wire logic laWrite,
  input wire logic [7:0] laValue,
  input wire logic [15:0] userEnd,
  input wire logic tagPresentPin,
  input wire logic prefetchDone,
  input wire logic directReq,
  input wire logic ptrReadReq,
  input wire logic [15:0] ptrValue,
  input wire logic [7:0] tagByte,
  input wire rhl_pkg::rhl_req_t bufRead,
  output logic [2:0] linkState,
  output logic rfFieldOn,
  output logic tagRelease,
  output logic writeErr,
  output logic writeAck,
  output logic directGrant,
  output logic directRefused,
  output logic [1:0] autoMode,
  output logic operative,
  output logic [7:0] lookAheadCount,
  output logic [15:0] tagAddr,
  output logic tagRdEn,
  output logic [7:0] bufData,
  output rhl_pkg::rhl_resp_t bufResp
);
  typedef enum {
    ST_DISC,
    ST_CONNECTING,
    ST_SIGNED_ON,
    ST_CONNECTED,
    ST_ERROR,
    ST_BUSY
  } rhl_state_t;

  rhl_state_t state_ff;
  rhl_state_t nxt_state;
  rhl_state_t target_ff;
  logic [2:0] nxt_linkState;
  logic presSync1_ff;
  logic presSync2_ff;
  logic presPrev_ff;
  logic signOn;
  logic tagLost;
  logic cmdOk;
  logic laBusy;
  logic [15:0] laTagAddr;
  logic laTagRdEn;
  logic cmdTake;
  logic directOk;
  rhl_pkg::rhl_req_t laPtrRead;

  function automatic logic [2:0] stateCode(input rhl_state_t s);
    case (s)
      ST_DISC: return rhl_pkg::LS_DISCONNECTED;
      ST_CONNECTING: return rhl_pkg::LS_CONNECTING;
      ST_SIGNED_ON: return rhl_pkg::LS_SIGNED_ON;
      ST_CONNECTED: return rhl_pkg::LS_CONNECTED;
      ST_ERROR: return rhl_pkg::LS_ERROR;
      ST_BUSY: return rhl_pkg::LS_BUSY;
      default: return rhl_pkg::LS_ERROR;
    endcase
  endfunction

  // field is lit in every state that can hold or await a tag
  function automatic logic fieldLit(input rhl_state_t s);
    return s == ST_CONNECTING || s == ST_SIGNED_ON || s == ST_CONNECTED;
  endfunction

  // a tag is signed on and not yet released
  function automatic logic inSession(input rhl_state_t s);
    return s == ST_SIGNED_ON || s == ST_CONNECTED;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // tag presence pin, two-stage synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presSync1_ff <= 1'b0;
      presSync2_ff <= 1'b0;
      presPrev_ff <= 1'b0;
    end else begin
      presSync1_ff <= tagPresentPin;
      presSync2_ff <= presSync1_ff;
      presPrev_ff <= presSync2_ff;
    end
  end

  // edges, not levels: a released tag still in the field must not sign on again
  assign signOn = presSync2_ff && !presPrev_ff;
  assign tagLost = !presSync2_ff && presPrev_ff;
  assign cmdOk = cmdCode >= rhl_pkg::CMD_CONNECT && cmdCode <= rhl_pkg::CMD_ERROR;
  // one decode of command acceptance shared by state, target and answer logic
  assign cmdTake = cmdWrite && cmdOk && state_ff != ST_BUSY;
  // direct access needs a held tag and auto mode off
  assign directOk = autoMode == rhl_pkg::AUTO_OFF && state_ff == ST_CONNECTED;

  ////////////////////////////////////////////////////////////////////////////
  // link state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_BUSY: nxt_state = target_ff;
      ST_CONNECTING: begin
        if (signOn) begin
          nxt_state = ST_SIGNED_ON;
        end
      end
      ST_SIGNED_ON: begin
        if (tagLost) begin
          nxt_state = ST_ERROR;
        end else if (prefetchDone && !laBusy) begin
          case (autoMode)
            rhl_pkg::AUTO_RECONNECT: nxt_state = ST_CONNECTING;
            rhl_pkg::AUTO_DISCONNECT: nxt_state = ST_DISC;
            default: nxt_state = ST_CONNECTED;
          endcase
        end
      end
      ST_CONNECTED: begin
        if (tagLost) begin
          nxt_state = ST_ERROR;
        end
      end
      ST_DISC: nxt_state = ST_DISC;
      // error is left only by a command, never by a new tag
      ST_ERROR: nxt_state = ST_ERROR;
      default: nxt_state = ST_ERROR;
    endcase
    // a valid command overrides events; state writes never alter it
    if (cmdTake) begin
      nxt_state = ST_BUSY;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_DISC;
      target_ff <= ST_DISC;
    end else begin
      state_ff <= nxt_state;
      if (cmdTake) begin
        case (cmdCode)
          rhl_pkg::CMD_CONNECT: target_ff <= ST_CONNECTING;
          rhl_pkg::CMD_DISCONNECT: target_ff <= ST_DISC;
          rhl_pkg::CMD_RECONNECT: target_ff <= ST_CONNECTING;
          rhl_pkg::CMD_ERROR: target_ff <= ST_ERROR;
          default: target_ff <= target_ff;
        endcase
      end
    end
  end

  assign nxt_linkState = stateCode(nxt_state);

  // field and tag release follow the next state so they align with linkState
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linkState <= rhl_pkg::LS_DISCONNECTED;
    end else begin
      linkState <= nxt_linkState;
    end
  end

  // field held through busy, so a command from a lit state never blinks it off
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rfFieldOn <= 1'b0;
    end else if (nxt_state != ST_BUSY) begin
      rfFieldOn <= fieldLit(nxt_state);
    end
  end

  // session end: any command but connect from a session, or auto completion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tagRelease <= 1'b0;
    end else begin
      tagRelease <= (cmdTake && cmdCode != rhl_pkg::CMD_CONNECT && inSession(state_ff))
        || (state_ff == ST_SIGNED_ON && !tagLost
        && (nxt_state == ST_CONNECTING || nxt_state == ST_DISC));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host write answers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      writeErr <= 1'b0;
    end else begin
      writeErr <= stateWrite || (cmdWrite && !cmdTake);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      writeAck <= 1'b0;
    end else begin
      writeAck <= cmdTake || autoWrite || operClear || laWrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control variables, writable regardless of tag presence
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      autoMode <= rhl_pkg::AUTO_RESET;
    end else if (autoWrite && autoValue != 2'h3) begin
      autoMode <= autoValue;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      operative <= rhl_pkg::OPERATIVE_RESET;
    end else if (operClear) begin
      operative <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lookAheadCount <= rhl_pkg::LOOKAHEAD_RESET;
    end else if (laWrite) begin
      lookAheadCount <= laValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direct tag access gate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      directGrant <= 1'b0;
      directRefused <= 1'b0;
    end else begin
      directGrant <= directReq && directOk;
      directRefused <= directReq && !directOk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // look-ahead engine
  assign laPtrRead = '{valid: ptrReadReq, addr: ptrValue};

  rhl_lookahead uLook (
    .mclk(mclk),
    .rst_n(rst_n),
    .ptrRead(laPtrRead),
    .count(lookAheadCount),
    .userEnd(userEnd),
    .tagByte(tagByte),
    .tagAddr(laTagAddr),
    .tagRdEn(laTagRdEn),
    .bufRead(bufRead),
    .bufData(bufData),
    .bufResp(bufResp),
    .busy(laBusy)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tagAddr <= 16'h0000;
      tagRdEn <= 1'b0;
    end else begin
      // pins registered for a clean address; the engine allows for the extra cycle
      tagAddr <= laTagAddr;
      tagRdEn <= laTagRdEn;
    end
  end
endmodule

// ### test/rhl_tag_model.sv
module rhl_tag_model (
  input wire logic mclk,
  input wire logic [15:0] tagAddr,
  input wire logic tagRdEn,
  output logic [7:0] tagByte
);
  timeunit 1ns;
  timeprecision 1ps;
  //////////////////////////////////////////////////
  // byte pattern derived from address; idle data toggles so stale bytes never match
  initial tagByte = 8'hA5;
  always @(posedge mclk) begin
    if (tagRdEn) begin
      tagByte <= tagAddr[7:0] ^ 8'h5A;
    end else begin
      tagByte <= ~tagByte;
    end
  end
endmodule

// ### test/rhl_link_ctrl_checker.sv
module rhl_link_ctrl_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdCode,
  input wire logic stateWrite,
  input wire logic directReq,
  input wire rhl_pkg::rhl_req_t bufRead,
  input wire logic [2:0] linkState,
  input wire logic rfFieldOn,
  input wire logic tagRelease,
  input wire logic writeErr,
  input wire logic writeAck,
  input wire logic directGrant,
  input wire logic directRefused,
  input wire logic [1:0] autoMode,
  input wire rhl_pkg::rhl_resp_t bufResp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////
  sequence s_busy;
    linkState == 3'h7;
  endsequence
  sequence s_wait;
    linkState == 3'h2 && rfFieldOn;
  endsequence
  property p_connect;
    cmdWrite && cmdCode == 3'h1 && linkState == 3'h1 |=> s_busy ##1 s_wait;
  endproperty
  a_connect: assert property (p_connect) else $error("connect path wrong");
  property p_badcode;
    cmdWrite && !(cmdCode inside {[3'h1:3'h4]}) && linkState == 3'h1
      |=> writeErr && !writeAck && linkState == 3'h1;
  endproperty
  a_badcode: assert property (p_badcode) else $error("bad code accepted");
  property p_statewr;
    stateWrite |=> writeErr && !writeAck;
  endproperty
  a_statewr: assert property (p_statewr) else $error("state write accepted");
  property p_off;
    linkState == 3'h1 || linkState == 3'h5 |-> !rfFieldOn;
  endproperty
  a_off: assert property (p_off) else $error("field on while off state");
  property p_on;
    linkState == 3'h2 |-> rfFieldOn;
  endproperty
  a_on: assert property (p_on) else $error("field off while connecting");
  property p_disc;
    cmdWrite && cmdCode == 3'h2 && (linkState == 3'h3 || linkState == 3'h4)
      |=> tagRelease && linkState == 3'h7 ##1 linkState == 3'h1;
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect path wrong");
  property p_direct;
    directReq |=> directRefused == !directGrant
      && directGrant == ($past(autoMode) == 2'h0 && $past(linkState) == 3'h4);
  endproperty
  a_direct: assert property (p_direct) else $error("direct answer wrong");
  property p_buf;
    bufRead.valid |=> bufResp.done;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer read unanswered");
  property p_busy;
    s_busy |=> linkState != 3'h7 && linkState != 3'h6 && linkState != 3'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
endmodule

bind rhl_link_ctrl rhl_link_ctrl_checker i_rhl_link_ctrl_checker (.mclk, .rst_n,
  .cmdWrite, .cmdCode, .stateWrite, .directReq, .bufRead, .linkState, .rfFieldOn,
  .tagRelease, .writeErr, .writeAck, .directGrant, .directRefused, .autoMode, .bufResp);

// ### test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, cmdWrite, stateWrite, autoWrite, operClear, laWrite;
  logic tagPresentPin, prefetchDone, directReq, ptrReadReq, rfFieldOn, tagRelease;
  logic writeErr, writeAck, directGrant, directRefused, operative, tagRdEn;
  logic [2:0] cmdCode, linkState;
  logic [1:0] autoValue, autoMode;
  logic [7:0] laValue, tagByte, lookAheadCount, bufData;
  logic [15:0] userEnd, ptrValue, tagAddr;
  rhl_pkg::rhl_req_t bufRead;
  rhl_pkg::rhl_resp_t bufResp;
  int errors, n_checks;

  rhl_link_ctrl i_rhl_link_ctrl (.mclk, .rst_n, .cmdWrite, .cmdCode, .stateWrite, .autoWrite,
    .autoValue, .operClear, .laWrite, .laValue, .userEnd, .tagPresentPin, .prefetchDone,
    .directReq, .ptrReadReq, .ptrValue, .tagByte, .bufRead, .linkState, .rfFieldOn,
    .tagRelease, .writeErr, .writeAck, .directGrant, .directRefused, .autoMode, .operative,
    .lookAheadCount, .tagAddr, .tagRdEn, .bufData, .bufResp);
  rhl_tag_model i_rhl_tag_model (.mclk, .tagAddr, .tagRdEn, .tagByte);

  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  //////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  // each request task lets one edge pass first, so no strobe drops and rises in one step
  task automatic cmd(input logic [2:0] c, input logic ok);
    tick;
    cmdWrite = 1;
    cmdCode = c;
    tick;
    cmdWrite = 0;
    chk(writeAck, ok);
    chk(writeErr, !ok);
  endtask
  task automatic setAuto(input logic [1:0] v);
    tick;
    autoWrite = 1;
    autoValue = v;
    tick;
    autoWrite = 0;
    chk(writeAck, 1);
    chk(autoMode, v);
  endtask
  task automatic dir(input logic ok);
    tick;
    directReq = 1;
    tick;
    directReq = 0;
    chk(directGrant, ok);
    chk(directRefused, !ok);
  endtask
  // the host waits for the expected state before it commands again
  task automatic go(input logic [2:0] s);
    for (int i = 0; i < 60 && linkState !== s; i++) tick;
    chk(linkState, s);
  endtask
  task automatic rel;
    for (int i = 0; i < 60 && tagRelease !== 1'b1; i++) tick;
    chk(tagRelease, 1);
  endtask
  task automatic rdBuf(input logic [7:0] i, input logic e, input logic [7:0] d);
    tick;
    bufRead = '{1'b1, {8'h00, i}};
    tick;
    bufRead.valid = 0;
    chk(bufResp.err, e);
    if (!e) chk(bufData, d);
  endtask
  //////////////////////////////////////////////////
  initial begin
    #40000;
    errors++;
    tally_and_finish;
  end
  initial begin
    {rst_n, cmdWrite, stateWrite, autoWrite, operClear, laWrite, directReq} = '0;
    {tagPresentPin, ptrReadReq, cmdCode, autoValue, laValue} = '0;
    prefetchDone = 1;
    userEnd = 16'h0102;
    ptrValue = 16'h0100;
    bufRead = '0;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1;
    chk(linkState, 3'h1);
    chk(rfFieldOn, 0);
    chk(autoMode, 2'h0);
    chk(operative, 1);
    chk(lookAheadCount, 8'h00);
    operClear = 1;
    tick;
    operClear = 0;
    chk(operative, 0);
    laWrite = 1;
    laValue = 8'h04;
    tick;
    laWrite = 0;
    chk(lookAheadCount, 8'h04);
    stateWrite = 1;
    tick;
    stateWrite = 0;
    chk(writeErr, 1);
    for (int k = 0; k < 4; k++) cmd(k == 0 ? 3'h0 : 3'(k + 4), 0);
    chk(linkState, 3'h1);
    cmd(3'h1, 1);
    chk(linkState, 3'h7);
    go(3'h2);
    chk(rfFieldOn, 1);
    dir(0);
    prefetchDone = 0;
    tagPresentPin = 1;
    go(3'h3);
    repeat (3) tick;
    chk(linkState, 3'h3);
    prefetchDone = 1;
    go(3'h4);
    dir(1);
    ptrReadReq = 1;
    tick;
    ptrReadReq = 0;
    tick;
    chk(tagAddr, 16'h0100);
    chk(tagRdEn, 1);
    repeat (2) tick;
    chk(tagAddr, 16'h0102);
    chk(tagRdEn, 0);
    repeat (9) tick;
    rdBuf(8'h00, 0, 8'h5A);
    rdBuf(8'h01, 0, 8'h5B);
    rdBuf(8'h02, 1, 8'h00);
    rdBuf(8'h03, 1, 8'h00);
    setAuto(2'h1);
    dir(0);
    setAuto(2'h0);
    tagPresentPin = 0;
    go(3'h5);
    chk(rfFieldOn, 0);
    cmd(3'h3, 1);
    go(3'h2);
    chk(rfFieldOn, 1);
    tagPresentPin = 1;
    go(3'h4);
    cmd(3'h2, 1);
    chk(tagRelease, 1);
    go(3'h1);
    chk(rfFieldOn, 0);
    rdBuf(8'h01, 0, 8'h5B);
    tagPresentPin = 0;
    setAuto(2'h1);
    cmd(3'h1, 1);
    go(3'h2);
    tagPresentPin = 1;
    rel;
    go(3'h2);
    chk(rfFieldOn, 1);
    tagPresentPin = 0;
    setAuto(2'h2);
    repeat (4) tick;
    tagPresentPin = 1;
    rel;
    go(3'h1);
    tagPresentPin = 0;
    setAuto(2'h0);
    cmd(3'h1, 1);
    go(3'h2);
    tagPresentPin = 1;
    go(3'h4);
    cmd(3'h4, 1);
    chk(tagRelease, 1);
    go(3'h5);
    chk(rfFieldOn, 0);
    tally_and_finish;
  end
endmodule
